// file: logic/rcs_bank.sv
// Selection registers for LED buses B and C, with per-phase current pick.
// Assumes the serial slave gives one-cycle write strobes on SYS_CLK and
// that level codes and phase come from same-clock logic.
`timescale 1ns/100ps
module rcs_bank (
    input  wire logic       SYS_CLK,
    input  wire logic       NRST,
    input  wire logic       CLK_EN,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic [7:0] RED_LEVEL_ZERO,
    input  wire logic [7:0] RED_LEVEL_ONE,
    input  wire logic [7:0] GREEN_LEVEL_ZERO,
    input  wire logic [7:0] GREEN_LEVEL_ONE,
    input  wire logic [7:0] BLUE_LEVEL_ZERO,
    input  wire logic [7:0] BLUE_LEVEL_ONE,
    input  wire logic [1:0] MUX_PHASE,
    output logic      [7:0] BUS_B_LINE_ONE,
    output logic      [7:0] BUS_B_LINE_TWO,
    output logic      [7:0] BUS_B_LINE_THREE,
    output logic      [7:0] BUS_B_LINE_FOUR,
    output logic      [7:0] BUS_C_LINE_ONE,
    output logic      [7:0] BUS_C_LINE_TWO,
    output logic      [7:0] BUS_C_LINE_THREE,
    output logic      [7:0] BUS_C_LINE_FOUR
);
    // ========================================================
    // Selection registers
    logic [7:0] bus_b_select_pair_12;
    logic [7:0] bus_b_select_pair_34;
    logic [7:0] bus_c_select_pair_12;
    logic [7:0] bus_c_select_pair_34;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            bus_b_select_pair_12 <= rcs_pkg::SEL_RESET;
            bus_b_select_pair_34 <= rcs_pkg::SEL_RESET;
            bus_c_select_pair_12 <= rcs_pkg::SEL_RESET;
            bus_c_select_pair_34 <= rcs_pkg::SEL_RESET;
        end else if (CLK_EN && REG_WR) begin
            case (REG_ADDR)
                rcs_pkg::OFS_B12: bus_b_select_pair_12 <= REG_WDATA;
                rcs_pkg::OFS_B34: bus_b_select_pair_34 <= REG_WDATA;
                rcs_pkg::OFS_C12: bus_c_select_pair_12 <= REG_WDATA;
                rcs_pkg::OFS_C34: bus_c_select_pair_34 <= REG_WDATA;
                default: ;
            endcase
        end
    end

    // Unmapped offsets read zero; another bank answers there
    logic [7:0] next_rdata;
    always_comb begin
        case (REG_ADDR)
            rcs_pkg::OFS_B12: next_rdata = bus_b_select_pair_12;
            rcs_pkg::OFS_B34: next_rdata = bus_b_select_pair_34;
            rcs_pkg::OFS_C12: next_rdata = bus_c_select_pair_12;
            rcs_pkg::OFS_C34: next_rdata = bus_c_select_pair_34;
            default:          next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            REG_RDATA <= 8'h00;
        end else if (CLK_EN) begin
            REG_RDATA <= next_rdata;
        end
    end

    // ========================================================
    // Field split
    logic       bus_b_rgb_one_on;
    logic       bus_b_rgb_two_on;
    logic       bus_b_rgb_three_on;
    logic       bus_b_rgb_four_on;
    logic       bus_c_rgb_one_on;
    logic       bus_c_rgb_two_on;
    logic       bus_c_rgb_three_on;
    logic       bus_c_rgb_four_on;
    logic [2:0] bus_b_rgb_one_pick;
    logic [2:0] bus_b_rgb_two_pick;
    logic [2:0] bus_b_rgb_three_pick;
    logic [2:0] bus_b_rgb_four_pick;
    logic [2:0] bus_c_rgb_one_pick;
    logic [2:0] bus_c_rgb_two_pick;
    logic [2:0] bus_c_rgb_three_pick;
    logic [2:0] bus_c_rgb_four_pick;

    assign bus_b_rgb_one_on   = bus_b_select_pair_12[rcs_pkg::EN_HI_POS];
    assign bus_b_rgb_two_on   = bus_b_select_pair_12[rcs_pkg::EN_LO_POS];
    assign bus_b_rgb_three_on = bus_b_select_pair_34[rcs_pkg::EN_HI_POS];
    assign bus_b_rgb_four_on  = bus_b_select_pair_34[rcs_pkg::EN_LO_POS];
    assign bus_c_rgb_one_on   = bus_c_select_pair_12[rcs_pkg::EN_HI_POS];
    assign bus_c_rgb_two_on   = bus_c_select_pair_12[rcs_pkg::EN_LO_POS];
    assign bus_c_rgb_three_on = bus_c_select_pair_34[rcs_pkg::EN_HI_POS];
    assign bus_c_rgb_four_on  = bus_c_select_pair_34[rcs_pkg::EN_LO_POS];
    assign bus_b_rgb_one_pick =
        bus_b_select_pair_12[rcs_pkg::SEL_HI_LSB +: 3];
    assign bus_b_rgb_two_pick =
        bus_b_select_pair_12[rcs_pkg::SEL_LO_LSB +: 3];
    assign bus_b_rgb_three_pick =
        bus_b_select_pair_34[rcs_pkg::SEL_HI_LSB +: 3];
    assign bus_b_rgb_four_pick =
        bus_b_select_pair_34[rcs_pkg::SEL_LO_LSB +: 3];
    assign bus_c_rgb_one_pick =
        bus_c_select_pair_12[rcs_pkg::SEL_HI_LSB +: 3];
    assign bus_c_rgb_two_pick =
        bus_c_select_pair_12[rcs_pkg::SEL_LO_LSB +: 3];
    assign bus_c_rgb_three_pick =
        bus_c_select_pair_34[rcs_pkg::SEL_HI_LSB +: 3];
    assign bus_c_rgb_four_pick =
        bus_c_select_pair_34[rcs_pkg::SEL_LO_LSB +: 3];

    // ========================================================
    // Level saturation
    logic [7:0] red0;
    logic [7:0] red1;
    logic [7:0] grn0;
    logic [7:0] grn1;
    logic [7:0] blu0;
    logic [7:0] blu1;

    function automatic logic [7:0] clamp_level(input logic [7:0] code);
        clamp_level = (code > rcs_pkg::LEVEL_MAX) ? rcs_pkg::LEVEL_MAX
                                                  : code;
    endfunction : clamp_level

    assign red0 = clamp_level(RED_LEVEL_ZERO);
    assign red1 = clamp_level(RED_LEVEL_ONE);
    assign grn0 = clamp_level(GREEN_LEVEL_ZERO);
    assign grn1 = clamp_level(GREEN_LEVEL_ONE);
    assign blu0 = clamp_level(BLUE_LEVEL_ZERO);
    assign blu1 = clamp_level(BLUE_LEVEL_ONE);

    // ========================================================
    // Per-phase routing; the rotation keeps the anode line dark
    function automatic logic [31:0] route(
        input logic [1:0] ph,
        input logic [3:0] on,
        input logic [2:0] p1,
        input logic [2:0] p2,
        input logic [2:0] p3,
        input logic [2:0] p4,
        input logic [7:0] r0,
        input logic [7:0] r1,
        input logic [7:0] g0,
        input logic [7:0] g1,
        input logic [7:0] b0,
        input logic [7:0] b1
    );
        logic [2:0] p;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        p = 3'h0;
        r = 8'h00;
        g = 8'h00;
        b = 8'h00;
        route = 32'h0;
        case (ph)
            2'b00:   p = p1;
            2'b01:   p = p2;
            2'b10:   p = p3;
            default: p = p4;
        endcase
        if (on[ph]) begin
            r = p[2] ? r1 : r0;
            g = p[1] ? g1 : g0;
            b = p[0] ? b1 : b0;
        end
        // Word lanes: [7:0] line one up to [31:24] line four
        case (ph)
            2'b00:   route = {b, r, g, 8'h00};
            2'b01:   route = {r, g, 8'h00, b};
            2'b10:   route = {g, 8'h00, b, r};
            default: route = {8'h00, b, r, g};
        endcase
    endfunction : route

    logic [31:0] next_b;
    logic [31:0] next_c;
    logic [3:0]  b_on;
    logic [3:0]  c_on;

    assign b_on = {bus_b_rgb_four_on, bus_b_rgb_three_on,
                   bus_b_rgb_two_on, bus_b_rgb_one_on};
    assign c_on = {bus_c_rgb_four_on, bus_c_rgb_three_on,
                   bus_c_rgb_two_on, bus_c_rgb_one_on};
    assign next_b = route(MUX_PHASE, b_on, bus_b_rgb_one_pick,
        bus_b_rgb_two_pick, bus_b_rgb_three_pick, bus_b_rgb_four_pick,
        red0, red1, grn0, grn1, blu0, blu1);
    assign next_c = route(MUX_PHASE, c_on, bus_c_rgb_one_pick,
        bus_c_rgb_two_pick, bus_c_rgb_three_pick, bus_c_rgb_four_pick,
        red0, red1, grn0, grn1, blu0, blu1);

    // Targets go to the fade engines, so a disabled RGB ramps to zero
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            {BUS_B_LINE_FOUR, BUS_B_LINE_THREE,
             BUS_B_LINE_TWO, BUS_B_LINE_ONE} <= 32'h0;
            {BUS_C_LINE_FOUR, BUS_C_LINE_THREE,
             BUS_C_LINE_TWO, BUS_C_LINE_ONE} <= 32'h0;
        end else if (CLK_EN) begin
            {BUS_B_LINE_FOUR, BUS_B_LINE_THREE,
             BUS_B_LINE_TWO, BUS_B_LINE_ONE} <= next_b;
            {BUS_C_LINE_FOUR, BUS_C_LINE_THREE,
             BUS_C_LINE_TWO, BUS_C_LINE_ONE} <= next_c;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    AST_B1_OFF: assert property (
        CLK_EN && MUX_PHASE == 2'b00 && !bus_b_rgb_one_on
        |=> BUS_B_LINE_THREE == 8'h00 && BUS_B_LINE_TWO == 8'h00
            && BUS_B_LINE_FOUR == 8'h00)
        else $error("Disabled B1 drives current");
    AST_B1_RED: assert property (
        CLK_EN && MUX_PHASE == 2'b00 && bus_b_rgb_one_on
        |=> BUS_B_LINE_THREE == ($past(bus_b_rgb_one_pick[2])
            ? $past(red1) : $past(red0)))
        else $error("B1 red pick wrong");
    AST_B2_BLUE: assert property (
        CLK_EN && MUX_PHASE == 2'b01 && bus_b_rgb_two_on
        |=> BUS_B_LINE_ONE == ($past(bus_b_rgb_two_pick[0])
            ? $past(blu1) : $past(blu0)))
        else $error("B2 blue pick wrong");
    AST_B3_GREEN: assert property (
        CLK_EN && MUX_PHASE == 2'b10 && bus_b_rgb_three_on
        |=> BUS_B_LINE_FOUR == ($past(bus_b_rgb_three_pick[1])
            ? $past(grn1) : $past(grn0)))
        else $error("B3 green pick wrong");
    AST_B4_OFF: assert property (
        CLK_EN && MUX_PHASE == 2'b11 && !bus_b_rgb_four_on
        |=> BUS_B_LINE_TWO == 8'h00 && BUS_B_LINE_ONE == 8'h00
            && BUS_B_LINE_THREE == 8'h00)
        else $error("Disabled B4 drives current");
    AST_C4_RED: assert property (
        CLK_EN && MUX_PHASE == 2'b11 && bus_c_rgb_four_on
        |=> BUS_C_LINE_TWO == ($past(bus_c_rgb_four_pick[2])
            ? $past(red1) : $past(red0)))
        else $error("C4 red pick wrong");
    // The clamped red reaches line three in phase one, so watch it there
    AST_SAT: assert property (
        BUS_B_LINE_ONE <= rcs_pkg::LEVEL_MAX
        && BUS_B_LINE_THREE <= rcs_pkg::LEVEL_MAX
        && BUS_C_LINE_THREE <= rcs_pkg::LEVEL_MAX)
        else $error("Level above maximum");
    AST_WR_RB: assert property (
        CLK_EN && REG_WR && REG_ADDR == rcs_pkg::OFS_C12
        ##1 CLK_EN && REG_ADDR == rcs_pkg::OFS_C12 && !REG_WR
        |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("C12 readback mismatch");
    AST_FREEZE: assert property (
        !CLK_EN |=> $stable(BUS_C_LINE_ONE) && $stable(REG_RDATA))
        else $error("State moved while disabled");
    AST_B2_OFF: assert property (
        CLK_EN && MUX_PHASE == 2'b01 && !bus_b_rgb_two_on
        |=> BUS_B_LINE_FOUR == 8'h00 && BUS_B_LINE_THREE == 8'h00
            && BUS_B_LINE_ONE == 8'h00)
        else $error("Disabled B2 drives current");
    AST_C1_GREEN: assert property (
        CLK_EN && MUX_PHASE == 2'b00 && bus_c_rgb_one_on
        |=> BUS_C_LINE_TWO == ($past(bus_c_rgb_one_pick[1])
            ? $past(grn1) : $past(grn0)))
        else $error("C1 green pick wrong");
    AST_C2_RED: assert property (
        CLK_EN && MUX_PHASE == 2'b01 && bus_c_rgb_two_on
        |=> BUS_C_LINE_FOUR == ($past(bus_c_rgb_two_pick[2])
            ? $past(red1) : $past(red0)))
        else $error("C2 red pick wrong");
    AST_C3_OFF: assert property (
        CLK_EN && MUX_PHASE == 2'b10 && !bus_c_rgb_three_on
        |=> BUS_C_LINE_ONE == 8'h00 && BUS_C_LINE_TWO == 8'h00
            && BUS_C_LINE_FOUR == 8'h00)
        else $error("Disabled C3 drives current");

    COV_B1_ON: cover property (
        bus_b_rgb_one_on && MUX_PHASE == 2'b00 ##1 BUS_B_LINE_THREE != 0);
    COV_C3_ON: cover property (
        bus_c_rgb_three_on && MUX_PHASE == 2'b10 ##1 BUS_C_LINE_ONE != 0);
    COV_CLAMP: cover property (RED_LEVEL_ONE > rcs_pkg::LEVEL_MAX);
endmodule : rcs_bank

// file: logic/rcs_pkg.sv
// Constants for the bus B/C current selection bank.
// Assumes an 8-bit register port decoded by the device's serial slave.
package rcs_pkg;
    // ========================================================
    // Register offsets
    localparam logic [7:0] OFS_B12 = 8'h0b;
    localparam logic [7:0] OFS_B34 = 8'h0c;
    localparam logic [7:0] OFS_C12 = 8'h0d;
    localparam logic [7:0] OFS_C34 = 8'h0e;
    // ========================================================
    // Field positions
    localparam int EN_HI_POS  = 7;
    localparam int SEL_HI_LSB = 4;
    localparam int EN_LO_POS  = 3;
    localparam int SEL_LO_LSB = 0;
    // ========================================================
    // Reset values and level ceiling
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] LEVEL_MAX = 8'hc0;
    localparam logic [7:0] LEVEL_OFF = 8'h00;
    // ========================================================
    // Multiplex phases
    typedef enum logic [1:0] {
        RCS_PH1 = 2'b00,
        RCS_PH2 = 2'b01,
        RCS_PH3 = 2'b10,
        RCS_PH4 = 2'b11
    } rcs_phase_t;
endpackage : rcs_pkg

// file: tb/rcs_host.sv
// Host model: stands in for the serial slave feeding the register port.
// Assumes SYS_CLK from the bench; requests move 1 ns after a rising edge.
`timescale 1ns/100ps
module rcs_host (
    input  wire logic       SYS_CLK,
    input  wire logic [7:0] REG_RDATA,
    output logic            REG_WR,
    output logic      [7:0] REG_ADDR,
    output logic      [7:0] REG_WDATA
);
    initial begin
        REG_WR    = 1'b0;
        REG_ADDR  = 8'h00;
        REG_WDATA = 8'h00;
    end
    // ========================================================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge SYS_CLK) #1;
        REG_WR    = 1'b1;
        REG_ADDR  = a;
        REG_WDATA = d;
        @(posedge SYS_CLK) #1;
        REG_WR    = 1'b0;
        // Inverted, so a stale byte never passes for fresh data
        REG_WDATA = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge SYS_CLK) #1;
        REG_ADDR = a;
        @(posedge SYS_CLK) #1;
        d = REG_RDATA;
    endtask : rd
endmodule : rcs_host

// file: tb/rgb_current_select_bank_bc_test.sv
// Self-checking bench for the bus B/C selection bank.
// Assumes the host model in rcs_host.sv; fixed level codes per colour except red one, swept for saturation.
`timescale 1ns/100ps
module rgb_current_select_bank_bc_test;
    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  data;
        logic [1:0]  ph;
        logic [63:0] exp;
    } rcs_row_t;
    logic       sys_clk = 1'b0;
    logic       nrst    = 1'b0;
    logic       clk_en  = 1'b1;
    logic [1:0] phase   = 2'b00;
    logic [7:0] rd_val;
    logic [7:0] lv [6]  = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    logic [7:0] sat_in  [4] = '{8'hbf, 8'hc0, 8'hc1, 8'hff};
    logic [7:0] sat_out [4] = '{8'hbf, 8'hc0, 8'hc0, 8'hc0};
    wire logic        reg_wr;
    wire logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire logic [63:0] lines;
    int         err_total    = 0;
    int         total_checks = 0;
    rcs_row_t   rows [10] = '{
        '{8'h0b, 8'hf0, 2'd0, 64'h00442266_00000000},
        '{8'h0b, 8'h0a, 2'd1, 64'h55004411_00000000},
        '{8'h0c, 8'hc0, 2'd2, 64'h22550033_00000000},
        '{8'h0c, 8'h0d, 2'd3, 64'h33226600_00000000},
        '{8'h0d, 8'h90, 2'd0, 64'h00000000_00331166},
        '{8'h0d, 8'h0f, 2'd1, 64'h00000000_66004422},
        '{8'h0e, 8'ha0, 2'd2, 64'h00000000_11550044},
        '{8'h0e, 8'h0e, 2'd3, 64'h00000000_44225500},
        '{8'h0b, 8'h70, 2'd0, 64'h0},
        '{8'h0c, 8'h08, 2'd2, 64'h0}};
    always #4 sys_clk = ~sys_clk;
    rcs_host host_u (.SYS_CLK(sys_clk), .REG_RDATA(reg_rdata),
        .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata));
    rcs_bank dut_u (.SYS_CLK(sys_clk), .NRST(nrst), .CLK_EN(clk_en),
        .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .RED_LEVEL_ZERO(lv[0]),
        .RED_LEVEL_ONE(lv[1]), .GREEN_LEVEL_ZERO(lv[2]),
        .GREEN_LEVEL_ONE(lv[3]), .BLUE_LEVEL_ZERO(lv[4]),
        .BLUE_LEVEL_ONE(lv[5]), .MUX_PHASE(phase),
        .BUS_B_LINE_ONE(lines[63:56]), .BUS_B_LINE_TWO(lines[55:48]),
        .BUS_B_LINE_THREE(lines[47:40]), .BUS_B_LINE_FOUR(lines[39:32]),
        .BUS_C_LINE_ONE(lines[31:24]), .BUS_C_LINE_TWO(lines[23:16]),
        .BUS_C_LINE_THREE(lines[15:8]), .BUS_C_LINE_FOUR(lines[7:0]));
    // ========================================================
    // Compare tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t reg read %h want %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t lines %h want %h", $time, got, exp);
        end
    endtask : chk64
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, rd_val);
        chk8(rd_val, e);
    endtask : rdchk
    // Two edges; the phase goes straight to routing and the output register takes it on the first
    task automatic lnchk(input logic [1:0] ph, input logic [63:0] e);
        phase = ph;
        repeat (2) @(posedge sys_clk);
        #1 chk64(lines, e);
    endtask : lnchk
    task automatic final_report;
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    // ========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 nrst = 1'b1;
        chk64(lines, 64'h0);
        for (int k = 0; k < 4; k++) begin
            rdchk(8'(8'h0b + k), 8'h00);
        end
        foreach (rows[i]) begin
            for (int k = 0; k < 4; k++) begin
                host_u.wr(8'(8'h0b + k), 8'h00);
            end
            host_u.wr(rows[i].addr, rows[i].data);
            rdchk(rows[i].addr, rows[i].data);
            lnchk(rows[i].ph, rows[i].exp);
        end
        // Saturation edge codes on the red level picked by bus B RGB one
        host_u.wr(8'h0c, 8'h00);
        host_u.wr(8'h0b, 8'hf0);
        foreach (sat_in[j]) begin
            lv[1] = sat_in[j];
            lnchk(2'd0, {16'h0044, sat_out[j], 8'h66, 32'h0});
        end
        lv[1] = 8'h22;
        // Bus A and unmapped offsets must leave the bank alone
        host_u.wr(8'h0a, 8'h0f);
        host_u.wr(8'h0f, 8'h0f);
        rdchk(8'h0f, 8'h00);
        rdchk(8'h0b, 8'hf0);
        clk_en = 1'b0;
        host_u.wr(8'h0b, 8'h00);
        clk_en = 1'b1;
        rdchk(8'h0b, 8'hf0);
        // Reset in mid-run clears registers and targets
        nrst = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk64(lines, 64'h0);
        nrst = 1'b1;
        rdchk(8'h0b, 8'h00);
        lnchk(2'd0, 64'h0);
        final_report();
    end
    initial begin
        #20000;
        err_total++;
        final_report();
    end
endmodule : rgb_current_select_bank_bc_test
